// ===== logic/stepper_map.svh
// Register offsets, field positions and reset values of the step sequencer.
// Assumes inclusion by its bare name from design and test files.
`ifndef STEPPER_MAP_SVH
`define STEPPER_MAP_SVH

`define OFS_CHOPPER_CONFIG  4'h0
`define OFS_HOLD_RUN        4'h4
`define OFS_LOAD_CONFIG     4'h8
`define OFS_LOWER_VEL       4'hc
`define OFS_UPPER_VEL       5'h10
`define OFS_STATUS          5'h14

`define RST_CHOPPER_CONFIG  32'h0000_0000
`define RST_HOLD_RUN        32'h0000_1f08
`define RST_LOAD_CONFIG     32'h0000_0000
`define RST_LOWER_VEL       32'h0000_0000
`define RST_UPPER_VEL       32'h0000_0000

`define POS_RES             0
`define POS_DEDGE           4
`define POS_FILTER          5
`define POS_RAMP_OFF        6
`define POS_STANDSTILL_CURRENT_SCALE           0
`define POS_RUN_CURRENT_SCALE            8
`define POS_LOWER_LOAD_THRESHOLD           0
`define POS_CURRENT_INCREMENT_SETTING            5
`define POS_LOAD_HYSTERESIS_WIDTH           8
`define POS_CURRENT_DECREMENT_SETTING            13
`define POS_SEIMIN          15

`define RES_FULL            4'h8
`define LOAD_SCALE_SHIFT    5
`define FILTER_DIV          2'h3
`define TABLE_SIZE          1024

`endif

// ===== logic/stepper_pkg.sv
// Types shared by the step sequencer files.
// Assumes nothing of its surroundings.
`default_nettype none
package stepper_pkg;
  typedef logic [9:0]  ustep_t;
  typedef logic [4:0]  cscale_t;
  typedef logic [31:0] word_t;
  typedef logic signed [8:0] coil_t;
  typedef logic [19:0] interval_t;
endpackage
`default_nettype wire

// ===== logic/pin_sync.sv
// Three-stage synchroniser for one pin with agreement filter.
// Assumes an asynchronous pin and the core clock.
`default_nettype none
module pin_sync (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level
);
  logic s1_reg, s2_reg, s3_reg, level_reg;
  logic level_next;

  always_comb begin
    level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s1_reg    <= 1'b0;
      s2_reg    <= 1'b0;
      s3_reg    <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      s1_reg    <= pin;
      s2_reg    <= s1_reg;
      s3_reg    <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;
endmodule
`default_nettype wire

// ===== logic/sine_lookup.sv
// Sine lookup over one electrical revolution of 1024 positions.
// Assumes a registered consumer; the output is combinational.
`default_nettype none
module sine_lookup (
  input  wire stepper_pkg::ustep_t idx,
  output stepper_pkg::coil_t       value
);
  import stepper_pkg::*;
  localparam logic [32:0][7:0] QTAB = {
    8'hff, 8'hff, 8'hfe, 8'hfc, 8'hfa, 8'hf7, 8'hf4, 8'hf0, 8'hec,
    8'he7, 8'he1, 8'hdb, 8'hd4, 8'hcd, 8'hc5, 8'hbd, 8'hb4, 8'hab,
    8'ha2, 8'h98, 8'h8e, 8'h83, 8'h78, 8'h6d, 8'h62, 8'h56, 8'h4a,
    8'h3e, 8'h32, 8'h25, 8'h19, 8'h0d, 8'h00};
  logic [8:0] x;
  logic [7:0] lo, hi, mag;
  logic [10:0] span;

  always_comb begin
    x = idx[8] ? (9'h100 - {1'b0, idx[7:0]}) : {1'b0, idx[7:0]};
    lo = QTAB[x[8:3]];
    hi = (x[8:3] == 6'h20) ? lo : QTAB[x[8:3] + 6'h01];
    span = 11'(hi - lo) * 11'(x[2:0]);
    mag = lo + span[10:3];
    value = idx[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  end
endmodule
`default_nettype wire

// ===== logic/step_sequencer.sv
// Step and direction sequencer with load-adaptive coil current scaling.
// Assumes an AXI4-Lite master on core_clk and load readings from logic on core_clk.
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`include "stepper_map.svh"
`default_nettype none
module step_sequencer (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 step_pin,
  input  wire logic                 dir_pin,
  input  wire logic [9:0]           load_measurement,
  input  wire logic                 load_valid,
  input  wire logic                 standstill,
  output stepper_pkg::ustep_t       ustep_position,
  output stepper_pkg::coil_t        coil_a_current,
  output stepper_pkg::coil_t        coil_b_current,
  output stepper_pkg::cscale_t      current_scale,
  output logic                      ramp_generator_enable,
  input  wire logic [5:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [5:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import stepper_pkg::*;

  // ****************************************
  // Register bus
  // ****************************************
  word_t chop_reg, chop_next, hr_reg, hr_next, lc_reg, lc_next;
  word_t lv_reg, lv_next, uv_reg, uv_next, rdata_reg, rdata_next;
  logic [5:0] awaddr_reg, awaddr_next;
  word_t wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic aw_full_reg, aw_full_next, w_full_reg, w_full_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  ustep_t cnt_reg;
  cscale_t cs_reg;

  function automatic word_t merge(word_t old, word_t d, logic [3:0] s);
    word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;

  always_comb begin
    chop_next = chop_reg;
    hr_next = hr_reg;
    lc_next = lc_reg;
    lv_next = lv_reg;
    uv_next = uv_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    aw_full_next = aw_full_reg;
    w_full_next = w_full_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      awaddr_next = s_axi_awaddr;
      aw_full_next = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
      w_full_next = 1'b1;
    end
    if (aw_full_reg && w_full_reg) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'b00;
      if (awaddr_reg[5:2] == `OFS_CHOPPER_CONFIG >> 2) begin
        chop_next = merge(chop_reg, wdata_reg, wstrb_reg) & 32'h0000_007f;
      end else if (awaddr_reg[5:2] == `OFS_HOLD_RUN >> 2) begin
        hr_next = merge(hr_reg, wdata_reg, wstrb_reg) & 32'h0000_1f1f;
      end else if (awaddr_reg[5:2] == `OFS_LOAD_CONFIG >> 2) begin
        lc_next = merge(lc_reg, wdata_reg, wstrb_reg) & 32'h0000_ff6f;
      end else if (awaddr_reg[5:2] == `OFS_LOWER_VEL >> 2) begin
        lv_next = merge(lv_reg, wdata_reg, wstrb_reg) & 32'h000f_ffff;
      end else if (awaddr_reg[5:2] == 4'(`OFS_UPPER_VEL >> 2)) begin
        uv_next = merge(uv_reg, wdata_reg, wstrb_reg) & 32'h000f_ffff;
      end else if (awaddr_reg[5:2] != 4'(`OFS_STATUS >> 2)) begin
        bresp_next = 2'b10;
      end
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rresp_next = 2'b00;
      if (s_axi_araddr[5:2] == `OFS_CHOPPER_CONFIG >> 2) begin
        rdata_next = chop_reg;
      end else if (s_axi_araddr[5:2] == `OFS_HOLD_RUN >> 2) begin
        rdata_next = hr_reg;
      end else if (s_axi_araddr[5:2] == `OFS_LOAD_CONFIG >> 2) begin
        rdata_next = lc_reg;
      end else if (s_axi_araddr[5:2] == `OFS_LOWER_VEL >> 2) begin
        rdata_next = lv_reg;
      end else if (s_axi_araddr[5:2] == 4'(`OFS_UPPER_VEL >> 2)) begin
        rdata_next = uv_reg;
      end else if (s_axi_araddr[5:2] == 4'(`OFS_STATUS >> 2)) begin
        rdata_next = {11'h000, cs_reg, 6'h00, cnt_reg};
      end else begin
        rdata_next = 32'h0000_0000;
        rresp_next = 2'b10;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chop_reg <= `RST_CHOPPER_CONFIG;
      hr_reg <= `RST_HOLD_RUN;
      lc_reg <= `RST_LOAD_CONFIG;
      lv_reg <= `RST_LOWER_VEL;
      uv_reg <= `RST_UPPER_VEL;
      awaddr_reg <= 6'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'b00;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'b00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      chop_reg <= chop_next;
      hr_reg <= hr_next;
      lc_reg <= lc_next;
      lv_reg <= lv_next;
      uv_reg <= uv_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign ramp_generator_enable = !chop_reg[`POS_RAMP_OFF];

  // ****************************************
  // Microstep sequencer
  // ****************************************
  logic step_level, dir_level, step_prev_reg, step_edge;
  logic [3:0] res_cfg, res_reg;
  ustep_t cnt_next, width, half, base;
  coil_t coil_a_reg, coil_b_reg, sin_a, sin_b;

  pin_sync u_step_sync (.core_clk(core_clk), .rst_n(rst_n), .pin(step_pin),
                        .level(step_level));
  pin_sync u_dir_sync (.core_clk(core_clk), .rst_n(rst_n), .pin(dir_pin),
                       .level(dir_level));

  always_comb begin
    res_cfg = (chop_reg[3:0] > `RES_FULL) ? `RES_FULL : chop_reg[3:0];
    step_edge = (step_level != step_prev_reg) &&
                (step_level || chop_reg[`POS_DEDGE]);
    width = ustep_t'(1) << res_cfg;
    half = width >> 1;
    base = cnt_reg;
    if (res_cfg != res_reg) begin
      base = ((cnt_reg + (half >> 1)) - half) & ~(width - ustep_t'(1));
      base = base + half;
    end
    cnt_next = base;
    if (step_edge) begin
      cnt_next = dir_level ? base - width : base + width;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      step_prev_reg <= 1'b0;
      res_reg <= 4'h0;
      cnt_reg <= 10'h000;
      coil_a_reg <= 9'sh000;
      coil_b_reg <= 9'sh000;
    end else begin
      step_prev_reg <= step_level;
      res_reg <= res_cfg;
      cnt_reg <= cnt_next;
      coil_a_reg <= sin_a;
      coil_b_reg <= sin_b;
    end
  end

  sine_lookup u_sin_a (.idx(cnt_reg), .value(sin_a));
  sine_lookup u_sin_b (.idx(cnt_reg + 10'h100), .value(sin_b));

  assign ustep_position = cnt_reg;
  assign coil_a_current = coil_a_reg;
  assign coil_b_current = coil_b_reg;

  // ****************************************
  // Load-adaptive current scaling
  // ****************************************
  interval_t ivl_cnt_reg, ivl_cnt_next, ivl_reg, ivl_next;
  logic [1:0] phase_reg, phase_next;
  logic [5:0] dec_reg, dec_next, dec_need;
  cscale_t cs_next, run_current_scale, standstill_current_scale, floor_cs;
  logic [9:0] lower_thr, upper_thr;
  logic [4:0] inc_w;
  logic [5:0] inc_sum;
  logic active, take;

  always_comb begin
    run_current_scale = hr_reg[`POS_RUN_CURRENT_SCALE +: 5];
    standstill_current_scale = hr_reg[`POS_STANDSTILL_CURRENT_SCALE +: 5];
    floor_cs = lc_reg[`POS_SEIMIN] ? run_current_scale >> 2 : run_current_scale >> 1;
    lower_thr = 10'(lc_reg[`POS_LOWER_LOAD_THRESHOLD +: 4]) << `LOAD_SCALE_SHIFT;
    upper_thr = (10'(lc_reg[`POS_LOWER_LOAD_THRESHOLD +: 4]) + 10'(lc_reg[`POS_LOAD_HYSTERESIS_WIDTH +: 4]) + 10'h001)
                << `LOAD_SCALE_SHIFT;
    inc_w = 5'h01 << lc_reg[`POS_CURRENT_INCREMENT_SETTING +: 2];
    case (lc_reg[`POS_CURRENT_DECREMENT_SETTING +: 2])
      2'h0: dec_need = 6'h20;
      2'h1: dec_need = 6'h08;
      2'h2: dec_need = 6'h02;
      default: dec_need = 6'h01;
    endcase
    active = !standstill && (lower_thr != 10'h000) &&
             (ivl_reg <= lv_reg[19:0]) && (ivl_reg > uv_reg[19:0]);
    take = load_valid && (!chop_reg[`POS_FILTER] || phase_reg == `FILTER_DIV);
    phase_next = load_valid ? phase_reg + 2'h1 : phase_reg;
    ivl_cnt_next = step_edge ? 20'h00000 :
                   (&ivl_cnt_reg ? ivl_cnt_reg : ivl_cnt_reg + 20'h00001);
    ivl_next = step_edge ? ivl_cnt_reg : (&ivl_cnt_reg ? ivl_cnt_reg : ivl_reg);
    inc_sum = {1'b0, cs_reg} + {1'b0, inc_w};
    dec_next = dec_reg;
    cs_next = cs_reg;
    if (!active) begin
      cs_next = standstill ? standstill_current_scale : run_current_scale;
      dec_next = 6'h00;
    end else begin
      if (take && load_measurement < lower_thr) begin
        cs_next = (inc_sum > {1'b0, run_current_scale}) ? run_current_scale : inc_sum[4:0];
        dec_next = 6'h00;
      end else if (take && load_measurement >= upper_thr) begin
        if (dec_reg + 6'h01 >= dec_need) begin
          dec_next = 6'h00;
          cs_next = (cs_reg > floor_cs) ? cs_reg - 5'h01 : floor_cs;
        end else begin
          dec_next = dec_reg + 6'h01;
        end
      end
      if (cs_next > run_current_scale) begin
        cs_next = run_current_scale;
      end else if (cs_next < floor_cs) begin
        cs_next = floor_cs;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ivl_cnt_reg <= 20'h00000;
      ivl_reg <= 20'hfffff;
      phase_reg <= 2'h0;
      dec_reg <= 6'h00;
      cs_reg <= 5'h00;
    end else begin
      ivl_cnt_reg <= ivl_cnt_next;
      ivl_reg <= ivl_next;
      phase_reg <= phase_next;
      dec_reg <= dec_next;
      cs_reg <= cs_next;
    end
  end

  assign current_scale = cs_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_step_adds: assert property (step_edge && !dir_level && res_cfg == res_reg |=>
    cnt_reg == $past(cnt_reg) + $past(width)) else $error("step up wrong");
  a_step_subs: assert property (step_edge && dir_level && res_cfg == res_reg |=>
    cnt_reg == $past(cnt_reg) - $past(width)) else $error("step down wrong");
  a_fall_ignored: assert property ($fell(step_level) && !chop_reg[`POS_DEDGE] &&
    res_cfg == res_reg |=> $stable(cnt_reg)) else $error("falling edge counted");
  a_full_positions: assert property ($past(res_cfg == `RES_FULL) && res_reg == `RES_FULL |->
    cnt_reg[7:0] == 8'h80) else $error("full step off grid");
  a_half_positions: assert property ($past(res_cfg == 4'h7) && res_reg == 4'h7 |->
    cnt_reg[6:0] == 7'h40) else $error("half step off grid");
  a_quarter_grid: assert property ($past(res_cfg == 4'h6) && res_reg == 4'h6 |->
    cnt_reg[5:0] == 6'h20) else $error("quarter step off grid");
  a_pin_latency: assert property ($changed(step_level) |->
    step_level == $past(step_pin, 3)) else $error("sync latency wrong");
  a_scale_bounds: assert property ($past(active) && active && $stable(run_current_scale) &&
    $stable(floor_cs) |-> cs_reg <= run_current_scale && cs_reg >= floor_cs)
    else $error("scale out of bounds");
  a_plain_current: assert property (!active && !standstill |=> cs_reg == $past(run_current_scale))
    else $error("run current not applied");
  a_filter_rate: assert property (load_valid && chop_reg[`POS_FILTER] && phase_reg != 2'h3 &&
    active && cs_reg <= run_current_scale && cs_reg >= floor_cs |=> $stable(cs_reg))
    else $error("filtered reading taken early");

  c_step_up: cover property (step_edge && !dir_level);
  c_res_change: cover property (res_cfg != res_reg);
  c_decrement: cover property (active && cs_next < cs_reg);
endmodule
`default_nettype wire

// ===== test/step_source.sv
// Behavioural motion controller driving the pulse and direction pins.
// Assumes the core clock and a caller that waits for each task to return.
`default_nettype none
module step_source (
  input  wire logic core_clk,
  output logic      step_pin,
  output logic      dir_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    step_pin = 1'b0;
    dir_pin  = 1'b0;
  end
  // One step: direction set four cycles ahead, edges four cycles apart.
  task automatic pulse(input logic dir, input logic both);
    @(posedge core_clk);
    dir_pin <= dir;
    repeat (4) @(posedge core_clk);
    step_pin <= both ? ~step_pin : 1'b1;
    repeat (4) @(posedge core_clk);
    if (!both) begin
      step_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    repeat (2) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ===== test/step_dir_microstep_sequencer_test.sv
// Self-checking bench of the step sequencer over its register bus and pins.
// Assumes the step sequencer design files and the behavioural controller.
`include "stepper_map.svh"
`default_nettype none
module step_dir_microstep_sequencer_test;
  import stepper_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_n, step_pin, dir_pin, load_valid, standstill;
  logic [9:0]  load_measurement, exp_pos;
  ustep_t      ustep_position;
  coil_t       coil_a_current, coil_b_current;
  cscale_t     current_scale;
  logic        ramp_generator_enable, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  word_t       rd;
  int          err_count, num_checks;

  step_source step_source_i (.core_clk, .step_pin, .dir_pin);
  step_sequencer step_sequencer_i (.core_clk, .rst_n, .step_pin, .dir_pin, .load_measurement,
    .load_valid, .standstill, .ustep_position, .coil_a_current, .coil_b_current, .current_scale,
    .ramp_generator_enable, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    if (err_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] a, input word_t d);
    logic ah, wh, bh;
    bh = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    while (!bh) begin
      @(negedge core_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge core_clk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
  endtask

  task automatic rd_reg(input logic [5:0] a);
    logic ah, rh;
    rh = 1'b0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    while (!rh) begin
      @(negedge core_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge core_clk);
      if (ah) s_axi_arvalid <= 1'b0;
    end
  endtask

  task automatic load(input logic [9:0] v, input int n);
    repeat (n) begin
      load_measurement <= v;
      load_valid       <= 1'b1;
      @(posedge core_clk);
      load_valid <= 1'b0;
      @(posedge core_clk);
    end
    @(posedge core_clk);
  endtask

  task automatic step_check(input logic dir, input int w);
    step_source_i.pulse(dir, 1'b0);
    exp_pos = dir ? exp_pos - 10'(w) : exp_pos + 10'(w);
    check("microstep position", ustep_position, exp_pos);
  endtask

  function automatic logic [9:0] snap(input logic [9:0] c, input int w);
    int t;
    t = ((int'(c) + w / 4 - w / 2) & ~(w - 1)) + w / 2;
    return 10'(t);
  endfunction

  function automatic word_t lcfg(input int up, input int dn, input int mn);
    return word_t'({mn[0], dn[1:0], 1'b0, 4'h1, 1'b0, up[1:0], 1'b0, 4'h2});
  endfunction

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    err_count = 0;
    num_checks = 0;
    rst_n = 1'b0;
    {load_valid, standstill, load_measurement} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    {s_axi_bready, s_axi_rready} = 2'b11;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check("counter reset", ustep_position, 32'h0);
    rd_reg(`OFS_HOLD_RUN);
    check("hold_run reset", rd, `RST_HOLD_RUN);
    rd_reg(6'h18);
    check("unmapped read response", 32'(resp), 32'h0000_0002);
    check("unmapped read data", rd, 32'h0000_0000);
    wr(6'h1c, 32'hffff_ffff);
    check("unmapped write", resp, 2'h2);
    check("ramp enable", ramp_generator_enable, 1'b1);
    wr(`OFS_CHOPPER_CONFIG, 32'h40);
    check("ramp disable", ramp_generator_enable, 1'b0);
    exp_pos = '0;
    for (int r = 0; r <= 8; r++) begin
      wr(`OFS_CHOPPER_CONFIG, word_t'(r));
      repeat (2) @(posedge core_clk);
      exp_pos = snap(exp_pos, 1 << r);
      check("snapped position", ustep_position, exp_pos);
      step_check(1'b0, 1 << r);
      step_check(1'b1, 1 << r);
      step_check(1'b1, 1 << r);
    end
    check("full step slot", exp_pos[7:0], 8'h80);
    check("full step coils", ((coil_a_current == coil_b_current) ||
      (coil_a_current == -coil_b_current)) && coil_a_current != 0 &&
      coil_a_current != 9'sd255 && coil_a_current != -9'sd255, 1'b1);
    rd_reg(`OFS_STATUS);
    check("status position", rd[9:0], exp_pos);
    wr(`OFS_CHOPPER_CONFIG, 32'h10);
    step_source_i.pulse(1'b0, 1'b1);
    step_source_i.pulse(1'b0, 1'b1);
    check("double edge", ustep_position, exp_pos + 10'd2);
    wr(`OFS_LOWER_VEL, 32'h000f_ffff);
    wr(`OFS_UPPER_VEL, 32'h0);
    wr(`OFS_LOAD_CONFIG, lcfg(2, 3, 0));
    load(10'h200, 20);
    check("floor half", current_scale, 5'd15);
    wr(`OFS_LOAD_CONFIG, lcfg(2, 3, 1));
    load(10'h200, 20);
    check("floor quarter", current_scale, 5'd7);
    load(10'd64, 1);
    load(10'd127, 1);
    check("between thresholds", current_scale, 5'd7);
    load(10'd63, 1);
    check("increment four", current_scale, 5'd11);
    wr(`OFS_LOAD_CONFIG, lcfg(3, 3, 1));
    load(10'd0, 1);
    check("increment eight", current_scale, 5'd19);
    load(10'd0, 2);
    check("ceiling", current_scale, 5'd31);
    wr(`OFS_LOAD_CONFIG, lcfg(3, 0, 1));
    load(10'd128, 31);
    check("slow decrement wait", current_scale, 5'd31);
    load(10'd128, 1);
    check("slow decrement", current_scale, 5'd30);
    wr(`OFS_LOAD_CONFIG, lcfg(3, 3, 1));
    wr(`OFS_CHOPPER_CONFIG, 32'h20);
    load(10'd128, 8);
    check("filtered rate", current_scale, 5'd28);
    standstill <= 1'b1;
    repeat (3) @(posedge core_clk);
    check("hold scale", current_scale, 5'd8);
    standstill <= 1'b0;
    wr(`OFS_LOWER_VEL, 32'h0);
    repeat (3) @(posedge core_clk);
    check("run scale", current_scale, 5'd31);
    wr(`OFS_LOWER_VEL, 32'h000f_ffff);
    wr(`OFS_UPPER_VEL, 32'h000f_fffe);
    load(10'h3ff, 8);
    check("above upper velocity", current_scale, 5'd31);
    tally_and_finish();
  end
endmodule
`default_nettype wire
